/* rate_gen_pkg.sv */
// package: register map, field positions and reset values of the rate generator
package rate_gen_pkg;
  localparam logic [2:0] ADDR_TX_CTRL = 3'h0;
  localparam logic [2:0] ADDR_RX_CTRL = 3'h1;
  localparam logic [2:0] ADDR_BAUD_CTRL = 3'h2;
  localparam logic [2:0] ADDR_DIV_HIGH = 3'h3;
  localparam logic [2:0] ADDR_DIV_LOW = 3'h4;
  localparam logic [2:0] ADDR_STATUS = 3'h5;
  localparam int ADDR_LSB = 2;
  localparam int ADDR_W = 3;
  localparam int SYNC_BIT = 4;
  localparam int HIGH_SPEED_BIT = 2;
  localparam int WIDE_BIT = 3;
  localparam int IDLE_BIT = 6;
  localparam int UNIMPL_BIT = 2;
  localparam logic [7:0] TX_CTRL_RST = 8'h02;
  localparam logic [7:0] RX_CTRL_RST = 8'h00;
  localparam logic [7:0] BAUD_CTRL_RST = 8'h00;
  localparam logic [7:0] DIV_RST = 8'h00;
  localparam logic [7:0] TX_CTRL_WMASK = 8'hFD;
  localparam logic [7:0] RX_CTRL_WMASK = 8'hF8;
  localparam logic [7:0] BAUD_CTRL_WMASK = 8'h3B;
  localparam logic [5:0] MULT_64 = 6'h3F;
  localparam logic [5:0] MULT_16 = 6'h0F;
  localparam logic [5:0] MULT_4 = 6'h03;
  typedef enum logic [1:0] {
    MULT_SEL_64 = 2'b00,
    MULT_SEL_16 = 2'b01,
    MULT_SEL_4 = 2'b10
  } mult_sel_t;
endpackage

/* rate_prescaler.sv */
// prescaler that multiplies each timer period by the selected multiplier
`timescale 1ns/10ps
module rate_prescaler
  import rate_gen_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // control
  input wire logic clear,
  input wire logic period_tick,
  input wire mult_sel_t mult_sel,
  // output
  output logic baud_tick
);
  logic [5:0] pre_ff;
  logic [5:0] nxt_pre;
  logic [5:0] limit;
  logic wrap;

  assign limit = (mult_sel == MULT_SEL_64) ? MULT_64 :
                 (mult_sel == MULT_SEL_16) ? MULT_16 : MULT_4;
  assign wrap = period_tick && (pre_ff >= limit);
  assign nxt_pre = clear ? 6'h00 : wrap ? 6'h00 : period_tick ? pre_ff + 6'h01 : pre_ff;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      pre_ff <= 6'h00;
      baud_tick <= 1'b0;
    end else begin
      pre_ff <= nxt_pre;
      baud_tick <= wrap && !clear;
    end
  end
endmodule

/* serial_baud_rate_generator.sv */
// serial port rate generator with classic wishbone register access
// Functional notes
// - eight-bit timer at reset, sixteen-bit when wide
// - free running, n+1 clocks per timer period
// - async multiplier from high-speed and wide bits
// - sync mode ignores the high-speed bit
// - async low 64 or 16, sync 4
// - divisor write clears the timer at once
// - wide divisor select is baud control bit 3
// - mode select is transmit control bit 4
`timescale 1ns/10ps
module serial_baud_rate_generator
  import rate_gen_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic wb_err_o,
  // receiver status pin
  input wire logic receiver_idle_flag,
  // rate outputs
  output logic baud_tick_o,
  output logic period_tick_o
);
  logic [7:0] tx_ctrl_ff;
  logic [7:0] rx_ctrl_ff;
  logic [7:0] baud_ctrl_ff;
  logic [7:0] div_high_ff;
  logic [7:0] div_low_ff;
  logic [15:0] count_ff;
  logic idle_s1_ff;
  logic idle_s2_ff;
  logic [31:0] rdata_ff;
  logic ack_ff;
  logic err_ff;
  logic period_ff;
  logic [15:0] nxt_count;
  logic [31:0] nxt_rdata;
  logic [7:0] nxt_tx_ctrl;
  logic [7:0] nxt_rx_ctrl;
  logic [7:0] nxt_baud_ctrl;
  logic [7:0] nxt_div_high;
  logic [7:0] nxt_div_low;
  logic nxt_period;
  logic nxt_ack;
  logic nxt_err;

  // bus decode
  wire req = wb_cyc_i && wb_stb_i && !ack_ff && !err_ff;
  wire [ADDR_W-1:0] reg_idx = wb_adr_i[ADDR_LSB+ADDR_W-1:ADDR_LSB];
  wire upper_zero = (wb_adr_i[7:ADDR_LSB+ADDR_W] == '0) && (wb_adr_i[1:0] == 2'b00);
  wire hit = upper_zero && (reg_idx <= ADDR_STATUS);
  wire wr_lane = req && hit && wb_we_i && wb_sel_i[0];
  wire wr_tx = wr_lane && (reg_idx == ADDR_TX_CTRL);
  wire wr_rx = wr_lane && (reg_idx == ADDR_RX_CTRL);
  wire wr_baud = wr_lane && (reg_idx == ADDR_BAUD_CTRL);
  wire wr_high = wr_lane && (reg_idx == ADDR_DIV_HIGH);
  wire wr_low = wr_lane && (reg_idx == ADDR_DIV_LOW);

  wire wide = baud_ctrl_ff[WIDE_BIT];
  wire sync_mode = tx_ctrl_ff[SYNC_BIT];
  wire high_speed = tx_ctrl_ff[HIGH_SPEED_BIT];

  wire mult_sel_t mult_sel = mult_sel_t'(sync_mode ? MULT_SEL_4 :
                                         (wide && high_speed) ? MULT_SEL_4 :
                                         (wide || high_speed) ? MULT_SEL_16 : MULT_SEL_64);

  // divisor width, low byte only when narrow
  wire [15:0] divisor = wide ? {div_high_ff, div_low_ff} : {8'h00, div_low_ff};
  wire [15:0] count_cmp = wide ? count_ff : {8'h00, count_ff[7:0]};
  wire period_end = (count_cmp >= divisor);
  wire div_wr = wr_high || wr_low;
  assign nxt_count = div_wr ? 16'h0000 : period_end ? 16'h0000 : count_ff + 16'h0001;

  wire [7:0] baud_rd = (baud_ctrl_ff & BAUD_CTRL_WMASK) | ({7'h00, idle_s2_ff} << IDLE_BIT);
  wire [7:0] status_rd = {5'h00, mult_sel == MULT_SEL_4, mult_sel == MULT_SEL_16, wide};
  wire [31:0] rd_sel_data = (reg_idx == ADDR_TX_CTRL) ? {24'h0, tx_ctrl_ff} :
                     (reg_idx == ADDR_RX_CTRL) ? {24'h0, rx_ctrl_ff} :
                     (reg_idx == ADDR_BAUD_CTRL) ? {24'h0, baud_rd} :
                     (reg_idx == ADDR_DIV_HIGH) ? {24'h0, div_high_ff} :
                     (reg_idx == ADDR_DIV_LOW) ? {24'h0, div_low_ff} :
                     {24'h0, status_rd};

  // register next values, read-only bits kept
  wire [7:0] tx_wval = (wb_dat_i[7:0] & TX_CTRL_WMASK) | (TX_CTRL_RST & ~TX_CTRL_WMASK);
  assign nxt_tx_ctrl = wr_tx ? tx_wval : tx_ctrl_ff;
  assign nxt_rx_ctrl = wr_rx ? (wb_dat_i[7:0] & RX_CTRL_WMASK) : rx_ctrl_ff;
  assign nxt_baud_ctrl = wr_baud ? (wb_dat_i[7:0] & BAUD_CTRL_WMASK) : baud_ctrl_ff;
  assign nxt_div_high = wr_high ? wb_dat_i[7:0] : div_high_ff;
  assign nxt_div_low = wr_low ? wb_dat_i[7:0] : div_low_ff;
  // period pulse, suppressed by a divisor write
  assign nxt_period = period_end && !div_wr;
  // bus answer one cycle after request
  assign nxt_ack = req && hit;
  assign nxt_err = req && !hit;
  assign nxt_rdata = (req && hit && !wb_we_i) ? rd_sel_data : rdata_ff;

  // transmit control register
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_ctrl_ff <= TX_CTRL_RST;
    end else begin
      tx_ctrl_ff <= nxt_tx_ctrl;
    end
  end

  // receive control register
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_ctrl_ff <= RX_CTRL_RST;
    end else begin
      rx_ctrl_ff <= nxt_rx_ctrl;
    end
  end

  // baud control register
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      baud_ctrl_ff <= BAUD_CTRL_RST;
    end else begin
      baud_ctrl_ff <= nxt_baud_ctrl;
    end
  end

  // divisor high byte
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      div_high_ff <= DIV_RST;
    end else begin
      div_high_ff <= nxt_div_high;
    end
  end

  // divisor low byte
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      div_low_ff <= DIV_RST;
    end else begin
      div_low_ff <= nxt_div_low;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      count_ff <= 16'h0000;
    end else begin
      count_ff <= nxt_count;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      period_ff <= 1'b0;
    end else begin
      period_ff <= nxt_period;
    end
  end

  // receiver idle flag synchroniser for software
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      idle_s1_ff <= 1'b1;
      idle_s2_ff <= 1'b1;
    end else begin
      idle_s1_ff <= receiver_idle_flag;
      idle_s2_ff <= idle_s1_ff;
    end
  end

  // bus acknowledge
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= nxt_ack;
    end
  end

  // bus error for unmapped addresses
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      err_ff <= 1'b0;
    end else begin
      err_ff <= nxt_err;
    end
  end

  // read data held until the next read
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_ff <= 32'h00000000;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  rate_prescaler u_pre (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .clear(div_wr),
    .period_tick(nxt_period),
    .mult_sel(mult_sel),
    .baud_tick(baud_tick_o)
  );

  assign wb_dat_o = rdata_ff;
  assign wb_ack_o = ack_ff;
  assign wb_err_o = err_ff;
  assign period_tick_o = period_ff;
endmodule

/* serial_baud_rate_generator_sva.sv */
// checker of bus answers and tick timing of the rate generator
`timescale 1ns/10ps
module serial_baud_rate_generator_sva (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // wishbone
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic wb_err_o,
  // ticks
  input wire logic baud_tick_o,
  input wire logic period_tick_o
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  wire req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  wire div_wr = req && wb_we_i && wb_sel_i[0] && wb_adr_i == 8'h10 && wb_dat_i[7:0] != 8'h00;
  a_answer_once: assert property (req |=> wb_ack_o ^ wb_err_o)
    else $error("no single answer");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  a_mapped_ack: assert property (req && wb_adr_i <= 8'h14 && wb_adr_i[1:0] == 2'h0 |=> wb_ack_o)
    else $error("mapped not acked");
  a_unmapped_err: assert property (req && wb_adr_i > 8'h14 |=> wb_err_o)
    else $error("unmapped not refused");
  a_idle_quiet: assert property (!wb_stb_i |=> !wb_ack_o && !wb_err_o)
    else $error("answer without request");
  a_read_upper: assert property ($rose(wb_ack_o) && !wb_we_i |-> wb_dat_o[31:8] == 24'h0)
    else $error("upper read bits set");
  a_div_clear: assert property (div_wr |=> ##1 !period_tick_o)
    else $error("timer not cleared");
  a_baud_gap: assert property (baud_tick_o |=> !baud_tick_o [*3])
    else $error("baud ticks too close");
  cover property (baud_tick_o);
  cover property (period_tick_o);
  cover property (wb_err_o);
endmodule
bind serial_baud_rate_generator serial_baud_rate_generator_sva u_chk (
  .sys_clk(sys_clk),
  .rst_b(rst_b),
  .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o),
  .wb_err_o(wb_err_o),
  .baud_tick_o(baud_tick_o),
  .period_tick_o(period_tick_o)
);

/* test_serial_baud_rate_generator.sv */
// testbench of the rate generator through its wishbone registers
`timescale 1ns/10ps
module test_serial_baud_rate_generator;
  logic sys_clk, rst_b, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, wb_err_o, e;
  logic receiver_idle_flag, baud_tick_o, period_tick_o;
  logic [7:0] wb_adr_i, q;
  logic [3:0] wb_sel_i, lanes;
  logic [31:0] wb_dat_i, wb_dat_o;
  int mismatches = 0, compares = 0, cyc = 0, m, n;
  serial_baud_rate_generator dut (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o),
    .wb_err_o(wb_err_o),
    .receiver_idle_flag(receiver_idle_flag),
    .baud_tick_o(baud_tick_o),
    .period_tick_o(period_tick_o)
  );
  initial begin
    sys_clk = 0;
    forever #5 sys_clk = ~sys_clk;
  end
  task end_of_test;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 40000) begin
      mismatches++;
      end_of_test;
    end
  end
  task chk(input string s, input logic [31:0] x, input logic [31:0] y);
    compares++;
    if (y !== x) begin
      mismatches++;
      $display("[ERR] %s exp %0h got %0h", s, x, y);
    end
  endtask
  // one classic cycle, held until answered
  task xf(input logic [7:0] a, input logic w, input logic [7:0] d);
    @(posedge sys_clk);
    wb_cyc_i <= 1;
    wb_stb_i <= 1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= {24'h0, d};
    wb_sel_i <= lanes;
    do @(posedge sys_clk); while (wb_ack_o !== 1 && wb_err_o !== 1);
    q = wb_dat_o[7:0];
    e = wb_err_o;
    wb_cyc_i <= 0;
    wb_stb_i <= 0;
  endtask
  // clocks to a tick, counted from the call or from a first tick
  task meas(input string s, input bit per, input bit from_tick, input int x);
    int c;
    c = 0;
    if (from_tick) begin
      do @(negedge sys_clk); while ((per ? period_tick_o : baud_tick_o) !== 1);
    end
    do begin
      @(negedge sys_clk);
      c++;
    end while ((per ? period_tick_o : baud_tick_o) !== 1);
    chk(s, x, c);
  endtask
  initial begin
    {wb_cyc_i, wb_stb_i, wb_we_i, rst_b, wb_adr_i, wb_dat_i} <= '0;
    wb_sel_i <= 4'h0;
    lanes = 4'h1;
    receiver_idle_flag <= 1;
    repeat (10) @(posedge sys_clk);
    rst_b <= 1;
    xf(8'h00, 0, 8'h00);
    chk("transmit_control", 32'h02, q);
    repeat (4) @(posedge sys_clk);
    xf(8'h08, 0, 8'h00);
    chk("baud_control", 32'h40, q);
    xf(8'h18, 0, 8'h00);
    chk("err", 1, e);
    xf(8'h09, 0, 8'h00);
    chk("misaligned err", 1, e);
    for (int i = 0; i < 8; i++) begin
      xf(8'h00, 1, {3'h0, i[2], 1'b0, i[0], 2'h0});
      xf(8'h08, 1, {4'h0, i[1], 3'h0});
      xf(8'h0C, 1, 8'h01);
      xf(8'h10, 1, 8'h02);
      m = i[2] ? 4 : i[1] ? (i[0] ? 4 : 16) : (i[0] ? 16 : 64);
      n = i[1] ? 258 : 2;
      meas("first period", 1, 0, n + 1);
      meas("period", 1, 1, n + 1);
      meas("baud period", 0, 1, m * (n + 1));
    end
    lanes = 4'h0;
    xf(8'h10, 1, 8'h55);
    lanes = 4'h1;
    xf(8'h10, 0, 8'h00);
    chk("divisor low", 32'h02, q);
    xf(8'h00, 0, 8'h00);
    chk("transmit_control", 32'h16, q);
    xf(8'h14, 0, 8'h00);
    chk("status", 32'h05, q);
    receiver_idle_flag <= 0;
    repeat (4) @(posedge sys_clk);
    xf(8'h08, 0, 8'h00);
    chk("idle", 0, q[6]);
    chk("baud_control", 32'h08, q);
    rst_b <= 0;
    repeat (3) @(posedge sys_clk);
    rst_b <= 1;
    repeat (3) @(posedge sys_clk);
    xf(8'h08, 0, 8'h00);
    chk("baud_control", 32'h00, q);
    meas("period", 1, 1, 1);
    meas("baud period", 0, 1, 64);
    end_of_test;
  end
endmodule
